// File: rtl/srx_cfg_regs.sv
// srx_cfg_regs: error masks, output controls and ancillary window
// What this block does
// - an 11-bit mask covers the stream-one error flags, bit 7 reserved.
// - a 7-bit mask covers the stream-two error flags, upper bits reserved.
// - clock register bit 5 picks in-phase (0) or quadrature (1) ddr clock.
// - clock register bits 4-0 hold the delay line offset, reset zero.
// - three 2-bit drive codes for upper data, status, lower data: 2, 2, 3.
// - with strict lock on, lock needs three words, last two same alignment.
// - the rate register bit 2 picks automatic (1) or manual (0), reset 1.
// - words 800h-BFFh read extracted ancillary data, upper byte on top.
`timescale 1ns/1ns
module srx_cfg_regs
	import srx_pkg::*;
#(
	parameter int ANC_DEPTH = SRX_ANC_DEPTH
)
(
	input wire logic ref_clk,
	input wire logic rst,
	input wire srx_req_t host_req,
	output srx_rsp_t host_rsp,
	input wire logic [SRX_S1_W-1:0] stream_one_faults,
	input wire logic [SRX_S2_W-1:0] stream_two_faults,
	output logic [SRX_S1_W-1:0] stream_one_error_vector,
	output logic [SRX_S2_W-1:0] stream_two_error_vector,
	output logic global_error,
	input wire logic anc_wr_en,
	input wire logic [$clog2(ANC_DEPTH)-1:0] anc_wr_index,
	input wire logic [7:0] anc_upper_byte,
	input wire logic [7:0] anc_lower_byte,
	input wire logic timing_reference_word,
	input wire logic [SRX_ALIGN_W-1:0] word_align,
	input wire logic lock_drop,
	output logic smpte_lock,
	output srx_cfg_t cfg
);

	localparam int IW = $clog2(ANC_DEPTH);

	// ==========================================================
	// configuration state
	logic [SRX_S1_W-1:0] mask1_r;
	logic [SRX_S1_W-1:0] mask1_nxt;
	logic [SRX_S2_W-1:0] mask2_r;
	logic [SRX_S2_W-1:0] mask2_nxt;
	srx_cfg_t cfg_r;
	srx_cfg_t cfg_nxt;
	srx_rsp_t rsp_r;
	srx_rsp_t rsp_nxt;
	logic [SRX_S1_W-1:0] vec1_r;
	logic [SRX_S1_W-1:0] vec1_nxt;
	logic [SRX_S2_W-1:0] vec2_r;
	logic [SRX_S2_W-1:0] vec2_nxt;
	logic gerr_r;
	logic gerr_nxt;
	logic wr;
	logic in_anc;
	logic [IW-1:0] rd_index;
	// ancillary word storage, read by the host path below
	logic [SRX_DW-1:0] anc_mem_r [ANC_DEPTH];
	logic [SRX_DW-1:0] anc_mem_nxt [ANC_DEPTH];

	// the whole host address is range-compared against the window base and last word
	assign wr = host_req.valid && host_req.write;
	assign in_anc = host_req.addr >= SRX_ANC_WINDOW_BASE
		&& host_req.addr <= SRX_ANC_WINDOW_LAST;
	assign rd_index = IW'(host_req.addr - SRX_ANC_WINDOW_BASE);

	// host writes; unmatched or read-only addresses fall through
	always_comb
	begin
		mask1_nxt = mask1_r;
		mask2_nxt = mask2_r;
		cfg_nxt = cfg_r;
		if (wr)
		begin
			unique case (host_req.addr)
				SRX_STREAM_ONE_ERROR_MASK:
				begin
					mask1_nxt = host_req.wdata[SRX_S1_W-1:0];
					mask1_nxt[SRX_S1_RSVD_BIT] = 1'b0;
				end
				SRX_STREAM_TWO_ERROR_MASK:
					mask2_nxt = host_req.wdata[SRX_S2_W-1:0];
				SRX_OUTPUT_CLOCK_DELAY_CONTROL:
				begin
					cfg_nxt.ddr_phase_choice =
						host_req.wdata[SRX_PHASE_BIT];
					cfg_nxt.delay_tap_offset =
						host_req.wdata[SRX_OFFSET_W-1:0];
				end
				SRX_OUTPUT_PAD_DRIVE_SELECT:
				begin
					cfg_nxt.upper_data_drive_code =
						host_req.wdata[SRX_UPPER_DRV_LSB +: 2];
					cfg_nxt.status_pin_drive_code =
						host_req.wdata[SRX_STAT_DRV_LSB +: 2];
					cfg_nxt.lower_data_drive_code =
						host_req.wdata[SRX_LOWER_DRV_LSB +: 2];
				end
				SRX_EQUALIZER_BYPASS_CONTROL:
					cfg_nxt.equalizer_skip = host_req.wdata[SRX_EQ_BIT];
				SRX_LOCK_NOISE_IMMUNITY_CONTROL:
					cfg_nxt.strict_lock_qualify =
						host_req.wdata[SRX_STRICT_BIT];
				SRX_RATE_SELECT:
				begin
					cfg_nxt.rate_detect_auto_select =
						host_req.wdata[SRX_AUTO_BIT];
					cfg_nxt.rate_manual_code = host_req.wdata[1:0];
				end
				default:
					cfg_nxt = cfg_r;
			endcase
		end
	end

	// read path; answer one cycle after the request
	always_comb
	begin
		rsp_nxt.valid = host_req.valid && !host_req.write;
		rsp_nxt.rdata = '0;
		if (in_anc)
			rsp_nxt.rdata = anc_mem_r[rd_index];
		else
		begin
			unique case (host_req.addr)
				SRX_STREAM_ONE_ERROR_MASK:
					rsp_nxt.rdata[SRX_S1_W-1:0] = mask1_r;
				SRX_STREAM_TWO_ERROR_MASK:
					rsp_nxt.rdata[SRX_S2_W-1:0] = mask2_r;
				SRX_OUTPUT_CLOCK_DELAY_CONTROL:
				begin
					rsp_nxt.rdata[SRX_PHASE_BIT] = cfg_r.ddr_phase_choice;
					rsp_nxt.rdata[SRX_OFFSET_W-1:0] = cfg_r.delay_tap_offset;
				end
				SRX_OUTPUT_PAD_DRIVE_SELECT:
				begin
					rsp_nxt.rdata[SRX_UPPER_DRV_LSB +: 2] =
						cfg_r.upper_data_drive_code;
					rsp_nxt.rdata[SRX_STAT_DRV_LSB +: 2] =
						cfg_r.status_pin_drive_code;
					rsp_nxt.rdata[SRX_LOWER_DRV_LSB +: 2] =
						cfg_r.lower_data_drive_code;
				end
				SRX_EQUALIZER_BYPASS_CONTROL:
					rsp_nxt.rdata[SRX_EQ_BIT] = cfg_r.equalizer_skip;
				SRX_LOCK_NOISE_IMMUNITY_CONTROL:
					rsp_nxt.rdata[SRX_STRICT_BIT] = cfg_r.strict_lock_qualify;
				SRX_RATE_SELECT:
				begin
					rsp_nxt.rdata[SRX_AUTO_BIT] = cfg_r.rate_detect_auto_select;
					rsp_nxt.rdata[1:0] = cfg_r.rate_manual_code;
				end
				default:
					rsp_nxt.rdata = '0;
			endcase
		end
	end

	// masked error vectors; reserved flag bit never reaches the vector
	always_comb
	begin
		vec1_nxt = stream_one_faults & ~mask1_r;
		vec1_nxt[SRX_S1_RSVD_BIT] = 1'b0;
		vec2_nxt = stream_two_faults & ~mask2_r;
		gerr_nxt = (|vec1_nxt) || (|vec2_nxt);
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			mask1_r <= '0;
			mask2_r <= '0;
			cfg_r.ddr_phase_choice <= 1'b0;
			cfg_r.delay_tap_offset <= '0;
			cfg_r.upper_data_drive_code <= SRX_UPPER_DRV_RST;
			cfg_r.status_pin_drive_code <= SRX_STAT_DRV_RST;
			cfg_r.lower_data_drive_code <= SRX_LOWER_DRV_RST;
			cfg_r.equalizer_skip <= 1'b0;
			cfg_r.rate_detect_auto_select <= SRX_AUTO_RST;
			cfg_r.rate_manual_code <= 2'h0;
			cfg_r.strict_lock_qualify <= 1'b0;
			rsp_r <= '0;
			vec1_r <= '0;
			vec2_r <= '0;
			gerr_r <= 1'b0;
		end
		else
		begin
			mask1_r <= mask1_nxt;
			mask2_r <= mask2_nxt;
			cfg_r <= cfg_nxt;
			rsp_r <= rsp_nxt;
			vec1_r <= vec1_nxt;
			vec2_r <= vec2_nxt;
			gerr_r <= gerr_nxt;
		end
	end

	// ==========================================================
	// ancillary word window, filled only by the extraction logic

	// host writes to the window are dropped, it is read-only
	always_comb
	begin
		anc_mem_nxt = anc_mem_r;
		if (anc_wr_en)
			anc_mem_nxt[anc_wr_index] = {anc_upper_byte, anc_lower_byte};
	end

	// reset clears the whole bank; costly in area but reads are defined
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			for (int i = 0; i < ANC_DEPTH; i++)
				anc_mem_r[i] <= '0;
		end
		else
			anc_mem_r <= anc_mem_nxt;
	end

	// ==========================================================
	// lock qualification; strict mode is meant for auto rate only
	srx_lock_qualify u_lock (
		.ref_clk(ref_clk),
		.rst(rst),
		.strict_lock_qualify(cfg_r.strict_lock_qualify),
		.timing_reference_word(timing_reference_word),
		.word_align(word_align),
		.lock_drop(lock_drop),
		.smpte_lock(smpte_lock)
	);

	assign host_rsp = rsp_r;
	assign cfg = cfg_r;
	assign stream_one_error_vector = vec1_r;
	assign stream_two_error_vector = vec2_r;
	assign global_error = gerr_r;

endmodule : srx_cfg_regs

// File: rtl/srx_pkg.sv
// srx_pkg: constants, types and register map of the receiver config bank
package srx_pkg;

	// ==========================================================
	// register access port
	localparam int SRX_AW = 12;
	localparam int SRX_DW = 16;

	typedef struct packed {
		logic valid;
		logic write;
		logic [SRX_AW-1:0] addr;
		logic [SRX_DW-1:0] wdata;
	} srx_req_t;

	typedef struct packed {
		logic valid;
		logic [SRX_DW-1:0] rdata;
	} srx_rsp_t;

	// ==========================================================
	// register offsets (word addresses on the host port)
	localparam logic [SRX_AW-1:0] SRX_RATE_SELECT = 12'h024;
	localparam logic [SRX_AW-1:0] SRX_STREAM_ONE_ERROR_MASK = 12'h037;
	localparam logic [SRX_AW-1:0] SRX_STREAM_TWO_ERROR_MASK = 12'h038;
	localparam logic [SRX_AW-1:0] SRX_OUTPUT_CLOCK_DELAY_CONTROL = 12'h06C;
	localparam logic [SRX_AW-1:0] SRX_OUTPUT_PAD_DRIVE_SELECT = 12'h06D;
	localparam logic [SRX_AW-1:0] SRX_EQUALIZER_BYPASS_CONTROL = 12'h073;
	localparam logic [SRX_AW-1:0] SRX_LOCK_NOISE_IMMUNITY_CONTROL = 12'h085;
	localparam logic [SRX_AW-1:0] SRX_ANC_WINDOW_BASE = 12'h800;
	localparam logic [SRX_AW-1:0] SRX_ANC_WINDOW_LAST = 12'hBFF;
	localparam int SRX_ANC_DEPTH = 1024;

	// ==========================================================
	// field widths and positions
	localparam int SRX_S1_W = 11;
	localparam int SRX_S2_W = 7;
	localparam int SRX_S1_RSVD_BIT = 7;
	localparam int SRX_AUTO_BIT = 2;
	localparam int SRX_PHASE_BIT = 5;
	localparam int SRX_OFFSET_W = 5;
	localparam int SRX_UPPER_DRV_LSB = 4;
	localparam int SRX_STAT_DRV_LSB = 2;
	localparam int SRX_LOWER_DRV_LSB = 0;
	localparam int SRX_EQ_BIT = 9;
	localparam int SRX_STRICT_BIT = 10;
	localparam int SRX_ALIGN_W = 4;

	// ==========================================================
	// values after reset
	localparam logic [1:0] SRX_UPPER_DRV_RST = 2'h2;
	localparam logic [1:0] SRX_STAT_DRV_RST = 2'h2;
	localparam logic [1:0] SRX_LOWER_DRV_RST = 2'h3;
	localparam logic SRX_AUTO_RST = 1'b1;
	localparam logic [1:0] SRX_TRS_NEED = 2'h2; // prior words before lock

	// ==========================================================
	// steering outputs grouped for the pad, clock, equalizer, rate and lock logic
	typedef struct packed {
		logic ddr_phase_choice;
		logic [SRX_OFFSET_W-1:0] delay_tap_offset;
		logic [1:0] upper_data_drive_code;
		logic [1:0] status_pin_drive_code;
		logic [1:0] lower_data_drive_code;
		logic equalizer_skip;
		logic rate_detect_auto_select;
		logic [1:0] rate_manual_code;
		logic strict_lock_qualify;
	} srx_cfg_t;

endpackage : srx_pkg

// File: rtl/srx_lock_qualify.sv
// srx_lock_qualify: declares video lock from timing reference words
`timescale 1ns/1ns
module srx_lock_qualify
	import srx_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic strict_lock_qualify,
	input wire logic timing_reference_word,
	input wire logic [SRX_ALIGN_W-1:0] word_align,
	input wire logic lock_drop,
	output logic smpte_lock
);

	// ==========================================================
	// word counting state
	logic [1:0] seen_r;
	logic [1:0] seen_nxt;
	logic [SRX_ALIGN_W-1:0] align_r;
	logic [SRX_ALIGN_W-1:0] align_nxt;
	logic lock_r;
	logic lock_nxt;

	// count words; a new alignment restarts the run at two prior words
	always_comb
	begin
		seen_nxt = seen_r;
		align_nxt = align_r;
		lock_nxt = lock_r;
		if (lock_drop)
		begin
			seen_nxt = 2'h0;
			lock_nxt = 1'b0;
		end
		else if (timing_reference_word)
		begin
			align_nxt = word_align;
			if (!strict_lock_qualify)
				lock_nxt = 1'b1;
			else if (seen_r >= SRX_TRS_NEED && word_align == align_r)
				lock_nxt = 1'b1;
			if (seen_r == 2'h0)
				seen_nxt = 2'h1;
			else if (word_align == align_r)
				seen_nxt = (seen_r == 2'h3) ? seen_r : seen_r + 2'h1;
			else
				seen_nxt = 2'h2;
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			seen_r <= 2'h0;
			align_r <= '0;
			lock_r <= 1'b0;
		end
		else
		begin
			seen_r <= seen_nxt;
			align_r <= align_nxt;
			lock_r <= lock_nxt;
		end
	end

	assign smpte_lock = lock_r;

endmodule : srx_lock_qualify

// File: test/srx_host_model.sv
// srx_host_model: host processor stand-in driving the register port
`timescale 1ns/1ns
module srx_host_model
	import srx_pkg::*;
(
	input wire logic ref_clk,
	output srx_req_t host_req,
	input wire srx_rsp_t host_rsp
);
	// ==========================================
	// host bus cycles
	// released lines invert so a stale value never looks like a request
	initial host_req = '0;

	// one write, taken at the first rising edge, no answer
	task automatic wr(input logic [SRX_AW-1:0] a, input logic [SRX_DW-1:0] d);
		@(negedge ref_clk);
		host_req = '{1'b1, 1'b1, a, d};
		@(negedge ref_clk);
		host_req.valid = 1'b0;
		host_req.addr = ~a;
		host_req.wdata = ~d;
	endtask : wr

	// one read; the answer stands for the cycle after the take edge
	task automatic rd(input logic [SRX_AW-1:0] a, output logic [SRX_DW-1:0] d,
		output logic v);
		@(negedge ref_clk);
		host_req = '{1'b1, 1'b0, a, ~host_req.wdata};
		@(negedge ref_clk);
		d = host_rsp.rdata;
		v = host_rsp.valid;
		host_req.valid = 1'b0;
		host_req.addr = ~a;
	endtask : rd
endmodule : srx_host_model

// File: test/srx_cfg_regs_chk.sv
// srx_cfg_regs_chk: port assertions of the config register bank
`timescale 1ns/1ns
module srx_cfg_regs_chk
	import srx_pkg::*;
#(
	parameter int ANC_DEPTH = SRX_ANC_DEPTH
)
(
	input wire logic ref_clk,
	input wire logic rst,
	input wire srx_req_t host_req,
	input wire srx_rsp_t host_rsp,
	input wire logic [SRX_S1_W-1:0] stream_one_faults,
	input wire logic [SRX_S1_W-1:0] stream_one_error_vector,
	input wire logic [SRX_S2_W-1:0] stream_two_error_vector,
	input wire logic global_error,
	input wire logic timing_reference_word,
	input wire logic lock_drop,
	input wire logic smpte_lock,
	input wire srx_cfg_t cfg
);
	// ==========================================
	// decoded requests
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	logic rd_q, wr_q, wr_s1, wr_clk, wr_drv;
	assign rd_q = host_req.valid && !host_req.write;
	assign wr_q = host_req.valid && host_req.write;
	assign wr_s1 = wr_q && host_req.addr == SRX_STREAM_ONE_ERROR_MASK;
	assign wr_clk = wr_q && host_req.addr == SRX_OUTPUT_CLOCK_DELAY_CONTROL;
	assign wr_drv = wr_q && host_req.addr == SRX_OUTPUT_PAD_DRIVE_SELECT;

	// ==========================================
	// assertions
	rsp_after_read_a: assert property (rd_q |=> host_rsp.valid)
		else $error("read got no answer");
	rsp_only_read_a: assert property (!rd_q |=> !host_rsp.valid)
		else $error("answer without a read");
	s1_rsvd_zero_a: assert property (!stream_one_error_vector[7])
		else $error("reserved vector bit set");
	global_or_a: assert property (global_error ==
		(|stream_one_error_vector || |stream_two_error_vector))
		else $error("global error not the or of vectors");
	s1_mask_apply_a: assert property (wr_s1 ##1 !wr_s1 |=>
		stream_one_error_vector == ($past(stream_one_faults) &
		~$past(host_req.wdata[10:0], 2) & 11'h77F))
		else $error("stream one mask not applied");
	clk_fields_a: assert property (wr_clk |=>
		cfg.ddr_phase_choice == $past(host_req.wdata[5]) &&
		cfg.delay_tap_offset == $past(host_req.wdata[4:0]))
		else $error("clock fields not stored");
	drive_codes_a: assert property (wr_drv |=>
		{cfg.upper_data_drive_code, cfg.status_pin_drive_code,
		cfg.lower_data_drive_code} == $past(host_req.wdata[5:0]))
		else $error("drive codes not stored");
	reset_cfg_a: assert property (disable iff (1'b0) rst |=>
		cfg.upper_data_drive_code == 2'h2 && cfg.status_pin_drive_code ==
		2'h2 && cfg.lower_data_drive_code == 2'h3 &&
		cfg.rate_detect_auto_select && !smpte_lock)
		else $error("reset values wrong");
	plain_lock_a: assert property (!cfg.strict_lock_qualify &&
		timing_reference_word && !lock_drop |=> smpte_lock)
		else $error("lock missed without strict mode");
	drop_clears_a: assert property (lock_drop |=> !smpte_lock)
		else $error("lock survived a drop");

	// main scenarios seen
	cover property (rd_q ##1 host_rsp.valid);
	cover property ($rose(smpte_lock) && cfg.strict_lock_qualify);
	cover property ($rose(global_error));
endmodule : srx_cfg_regs_chk

bind srx_cfg_regs srx_cfg_regs_chk #(.ANC_DEPTH(ANC_DEPTH)) chk (
	.ref_clk(ref_clk), .rst(rst), .host_req(host_req), .host_rsp(host_rsp),
	.stream_one_faults(stream_one_faults),
	.stream_one_error_vector(stream_one_error_vector),
	.stream_two_error_vector(stream_two_error_vector),
	.global_error(global_error), .lock_drop(lock_drop),
	.timing_reference_word(timing_reference_word),
	.smpte_lock(smpte_lock), .cfg(cfg));

// File: test/test_srx_cfg_regs.sv
// test_srx_cfg_regs: self-checking bench of the config register bank
`timescale 1ns/1ns
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin bad_count++; \
	$display("[FAIL] %0t got %h want %h", $time, g, e); end end
module test_srx_cfg_regs
	import srx_pkg::*;
;
	typedef struct packed {
		logic [11:0] a;
		logic [15:0] w;
		logic [15:0] r;
		logic [15:0] e;
	} srx_row_t;
	// ==========================================
	// signals, design and host
	logic ref_clk = 1'b0, rst = 1'b1, aen = 1'b0, trw = 1'b0, drop = 1'b0;
	logic [10:0] s1f = '0, v1;
	logic [6:0] s2f = '0, v2;
	logic [9:0] aidx = '0;
	logic [7:0] aup = '0, alo = '0;
	logic [3:0] align = '0;
	logic [15:0] d;
	logic v, gerr, lock;
	srx_req_t host_req;
	srx_rsp_t host_rsp;
	srx_cfg_t cfg;
	int bad_count = 0, num_checks = 0;
	// address, write data, reset readback, readback after write
	srx_row_t rows [10] = '{
		'{12'h037, 16'hFFFF, 16'h0000, 16'h077F},
		'{12'h038, 16'hFFFF, 16'h0000, 16'h007F},
		'{12'h06C, 16'hFFFF, 16'h0000, 16'h003F},
		'{12'h06D, 16'h0000, 16'h002B, 16'h0000},
		'{12'h073, 16'hFFFF, 16'h0000, 16'h0200},
		'{12'h024, 16'hFFFF, 16'h0004, 16'h0007},
		'{12'h085, 16'hFFFF, 16'h0000, 16'h0400},
		'{12'h039, 16'hFFFF, 16'h0000, 16'h0000},
		'{12'h800, 16'h1234, 16'h0000, 16'h0000},
		'{12'hC00, 16'hFFFF, 16'h0000, 16'h0000}};
	srx_cfg_regs #(.ANC_DEPTH(1024)) dut (.ref_clk(ref_clk), .rst(rst),
		.host_req(host_req), .host_rsp(host_rsp), .stream_one_faults(s1f),
		.stream_two_faults(s2f), .stream_one_error_vector(v1),
		.stream_two_error_vector(v2), .global_error(gerr), .anc_wr_en(aen),
		.anc_wr_index(aidx), .anc_upper_byte(aup), .anc_lower_byte(alo),
		.timing_reference_word(trw), .word_align(align), .lock_drop(drop),
		.smpte_lock(lock), .cfg(cfg));
	srx_host_model host (.ref_clk(ref_clk), .host_req(host_req),
		.host_rsp(host_rsp));

	// 125 MHz clock
	always #4 ref_clk = ~ref_clk;

	// ==========================================
	// helpers
	task automatic cyc(input int n);
		repeat (n) @(negedge ref_clk);
	endtask : cyc
	// back-to-back reference words, alignments packed four bits each
	task automatic words(input logic [11:0] al, input int n);
		trw = 1'b1;
		for (int i = 0; i < n; i++)
		begin
			align = al[4*i +: 4];
			cyc(1);
		end
		trw = 1'b0;
		cyc(2);
	endtask : words
	task automatic dropit();
		drop = 1'b1;
		cyc(1);
		drop = 1'b0;
		cyc(1);
	endtask : dropit
	task automatic conclude();
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : conclude

	// watchdog: the run needs well under 1000 cycles
	initial
	begin
		#20000;
		bad_count++;
		conclude();
	end

	// ==========================================
	// main sequence
	initial
	begin
		cyc(5);
		rst = 1'b0;
		foreach (rows[i])
		begin
			host.rd(rows[i].a, d, v);
			`CHK(v, 1'b1)
			`CHK(d, rows[i].r)
			host.wr(rows[i].a, rows[i].w);
			host.rd(rows[i].a, d, v);
			`CHK(d, rows[i].e)
		end
		$display("test table done");
		host.wr(SRX_STREAM_ONE_ERROR_MASK, 16'h0005);
		host.wr(SRX_STREAM_TWO_ERROR_MASK, 16'h0001);
		s1f = '1;
		s2f = '1;
		cyc(2);
		`CHK(v1, 11'h77A)
		`CHK(v2, 7'h7E)
		`CHK(gerr, 1'b1)
		s1f = '0;
		s2f = '0;
		cyc(2);
		`CHK(gerr, 1'b0)
		$display("test masks done");
		// last window word, then a write there must not disturb it
		aen = 1'b1;
		aidx = 10'h3FF;
		aup = 8'hA5;
		alo = 8'h3C;
		cyc(1);
		aen = 1'b0;
		host.rd(SRX_ANC_WINDOW_LAST, d, v);
		`CHK(d, 16'hA53C)
		host.wr(SRX_ANC_WINDOW_LAST, 16'h0000);
		host.rd(SRX_ANC_WINDOW_LAST, d, v);
		`CHK(d, 16'hA53C)
		$display("test window done");
		// strict mode set while auto rate detect is on
		words(12'h021, 2);
		`CHK(lock, 1'b0)
		words(12'h002, 1);
		`CHK(lock, 1'b1)
		dropit();
		`CHK(lock, 1'b0)
		words(12'h555, 3);
		`CHK(lock, 1'b1)
		dropit();
		words(12'h005, 1);
		`CHK(lock, 1'b0)
		host.wr(SRX_LOCK_NOISE_IMMUNITY_CONTROL, 16'h0000);
		dropit();
		words(12'h005, 1);
		`CHK(lock, 1'b1)
		$display("test lock done");
		rst = 1'b1;
		cyc(2);
		rst = 1'b0;
		host.rd(SRX_OUTPUT_PAD_DRIVE_SELECT, d, v);
		`CHK(d, 16'h002B)
		host.rd(SRX_STREAM_ONE_ERROR_MASK, d, v);
		`CHK(d, 16'h0000)
		`CHK(cfg.rate_detect_auto_select, 1'b1)
		`CHK(lock, 1'b0)
		$display("test reset done");
		conclude();
	end
endmodule : test_srx_cfg_regs
